// ---- hdl/fmrx_pkg.sv ----
// Shared constants of the FM receiver command core: timing, opcodes,
// status layout and the property table with its reset defaults.
// Assumes a 40 MHz system clock and a byte-wide link on its own clock.
package fmrx_pkg;
   localparam int CLK_PERIOD_NS = 25;
   localparam int TUNE_TIME_US  = 60;
   localparam int TUNE_CYC      = (TUNE_TIME_US * 1000) / CLK_PERIOD_NS;
   localparam int CMD_BYTES     = 8;
   localparam int RESP_BYTES    = 16;
   localparam int RESP_USED     = 5;
   localparam int SYNC_W        = 7;
   // Opcodes.
   localparam logic [7:0] CMD_POWER_UP        = 8'h01;
   localparam logic [7:0] CMD_READ_REVISION   = 8'h10;
   localparam logic [7:0] CMD_POWER_DOWN      = 8'h11;
   localparam logic [7:0] CMD_WRITE_SETTING   = 8'h12;
   localparam logic [7:0] CMD_READ_SETTING    = 8'h13;
   localparam logic [7:0] CMD_READ_IRQ_FLAGS  = 8'h14;
   localparam logic [7:0] CMD_FW_DL_ARGS      = 8'h15;
   localparam logic [7:0] CMD_FW_DL_PAYLOAD   = 8'h16;
   localparam logic [7:0] CMD_TUNE_CHANNEL    = 8'h20;
   localparam logic [7:0] CMD_BEGIN_SEARCH    = 8'h21;
   localparam logic [7:0] CMD_TUNING_REPORT   = 8'h22;
   localparam logic [7:0] CMD_QUALITY_REPORT  = 8'h23;
   localparam logic [7:0] CMD_RDS_REPORT      = 8'h24;
   localparam logic [7:0] CMD_PIN_DIRECTION   = 8'h80;
   localparam logic [7:0] CMD_PIN_LEVEL       = 8'h81;
   // Status byte bits; flags sit at bits 2..0 (data, quality, tune).
   localparam int ST_READY_BIT = 7;
   localparam int ST_ERR_BIT   = 6;
   // Power-up and seek argument bits.
   localparam int PU_XTAL_BIT    = 4;
   localparam int PU_ANALOG_BIT  = 0;
   localparam int PU_DIGITAL_BIT = 4;
   localparam int SEEK_UP_BIT    = 3;
   // Setting limits.
   localparam logic [15:0] REFCLK_MIN = 16'h799A;
   localparam logic [15:0] REFCLK_MAX = 16'h8666;
   localparam logic [15:0] BLEND_MONO = 16'h007F;
   // Setting table: identifier and value after reset.
   localparam int PROP_NUM = 27;
   localparam logic [15:0] PROP_ID [PROP_NUM] = '{
      16'h0001, 16'h0102, 16'h0104, 16'h0201, 16'h0202, 16'h1100, 16'h1105,
      16'h1106, 16'h1108, 16'h1200, 16'h1201, 16'h1202, 16'h1203, 16'h1204,
      16'h1207, 16'h1302, 16'h1303, 16'h1400, 16'h1401, 16'h1402, 16'h1403,
      16'h1404, 16'h1500, 16'h1501, 16'h1502, 16'h4000, 16'h4001};
   localparam logic [15:0] PROP_DEF [PROP_NUM] = '{
      16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0001, 16'h0002, 16'h0031,
      16'h001E, 16'h001E, 16'h0000, 16'h007F, 16'h0000, 16'h007F, 16'h0000,
      16'h0081, 16'h0010, 16'h0004, 16'h222E, 16'h2A26, 16'h000A, 16'h0003,
      16'h0014, 16'h0000, 16'h0000, 16'h0000, 16'h003F, 16'h0000};
   // Table positions read by the core.
   localparam int P_IRQ_EN   = 0;
   localparam int P_DA_RATE  = 2;
   localparam int P_REFCLK   = 3;
   localparam int P_STEREO   = 6;
   localparam int P_MONO     = 7;
   localparam int P_MAX_ERR  = 8;
   localparam int P_QUAL_SRC = 9;
   localparam int P_SNR_HI   = 10;
   localparam int P_SNR_LO   = 11;
   localparam int P_RSSI_HI  = 12;
   localparam int P_RSSI_LO  = 13;
   localparam int P_SMUTE    = 15;
   localparam int P_BAND_LO  = 17;
   localparam int P_BAND_HI  = 18;
   localparam int P_SPACING  = 19;
   localparam int P_RDS_SRC  = 22;
   localparam int P_RDS_LVL  = 23;
   localparam int P_MUTE     = 26;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_EXEC = 2'b10} fmrx_state_t;
endpackage

// ---- hdl/fmrx_prop_store.sv ----
// Setting store of the FM receiver core: one 16-bit word per table entry.
// Assumes writes come from the command engine on the same clock.
`timescale 1ns/1ps
`default_nettype none
module fmrx_prop_store
   import fmrx_pkg::*;
(
   // Clock and reset.
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Lookup and write.
   input  wire logic        wr_in,
   input  wire logic [15:0] id_in,
   input  wire logic [15:0] data_in,
   output logic             hit_out,
   output logic [15:0]      rd_out,
   // All values.
   output logic [15:0]      vals_out [PROP_NUM]
);
   logic [PROP_NUM-1:0] match;

   // Each entry reloads its default in reset and takes matching writes.
   for (genvar i = 0; i < PROP_NUM; i++) begin : g_prop
      assign match[i] = (id_in == PROP_ID[i]);
      always_ff @(posedge clk_in) begin
         if (rst_in) begin
            vals_out[i] <= PROP_DEF[i];
         end else if (wr_in && match[i]) begin
            vals_out[i] <= data_in;
         end
      end
   end

   // Read selection of the matching entry.
   always_comb begin
      rd_out = 16'h0000;
      for (int k = 0; k < PROP_NUM; k++) begin
         if (match[k]) begin
            rd_out = vals_out[k];
         end
      end
   end

   assign hit_out = |match;
endmodule
`default_nettype wire

// ---- hdl/fmrx_core.sv ----
// Command and setting engine of the FM receiver with its link front end.
// Assumes a framer on link_clk_in that delivers command bytes and reads
// answer bytes by index; the radio path feeds measurements on sys_clk_in.
`timescale 1ns/1ps
`default_nettype none
module fmrx_core #(
   parameter logic [7:0] PART_ID = 8'h5A // Arbitrary identity value.
) (
   // System clock and reset.
   input  wire logic        sys_clk_in,
   input  wire logic        rst_in,
   // Link side.
   input  wire logic        link_clk_in,
   input  wire logic        link_wr_valid_in,
   input  wire logic [7:0]  link_wr_byte_in,
   input  wire logic        link_wr_last_in,
   input  wire logic [3:0]  link_rd_idx_in,
   output logic [7:0]       link_rd_byte_out,
   // Radio measurements.
   input  wire logic signed [7:0] freq_err_in,
   input  wire logic [7:0]  rssi_in,
   input  wire logic [7:0]  snr_in,
   input  wire logic [7:0]  rds_count_in,
   output logic             rds_pop_out,
   // Radio controls.
   output logic             analog_en_out,
   output logic             digital_audio_en_out,
   output logic             xtal_sel_out,
   output logic             freq_ctl_en_out,
   output logic             stereo_force_out,
   output logic             mono_force_out,
   output logic             softmute_en_out,
   output logic             mute_left_out,
   output logic             mute_right_out,
   output logic [15:0]      tune_freq_out,
   // General output pins.
   output logic [2:0]       general_output_pin_out,
   output logic [2:0]       general_output_pin_oe_out
);
   import fmrx_pkg::*;

   localparam int TCW = $clog2(TUNE_CYC + 1);
   localparam logic [TCW-1:0] TUNE_LOAD = TCW'(TUNE_CYC);

   // ---- Link domain state.
   logic [7:0]        cmd_buf_r [CMD_BYTES];
   logic [3:0]        cmd_cnt_r;
   logic              req_tgl_r;
   logic [SYNC_W-1:0] lsync1_r, lsync2_r;
   logic [7:0]        rd_byte_r;
   // ---- System domain state.
   fmrx_state_t       state_r;
   logic              req_s1_r, req_s2_r, req_s3_r;
   logic              ack_tgl_r, ready_r, err_r, bus_en_r;
   logic              powered_r, digital_r, analog_r, xtal_r;
   logic [2:0]        irq_r;
   logic [15:0]       freq_r;
   logic [TCW-1:0]    tune_cnt_r;
   logic [7:0]        resp_r [1:RESP_USED];
   logic [7:0]        resp_nxt [1:RESP_USED];
   logic [2:0]        pin_oe_r, pin_lvl_r, pin_out_r, pin_oen_r;
   logic              pop_r;
   logic [8:0]        ctl_r;

   // Link view of system flags after two flops.
   wire bus_en_s  = lsync2_r[6];
   wire ack_s     = lsync2_r[5];
   wire err_s     = lsync2_r[4];
   wire ready_s   = lsync2_r[3];
   wire [2:0] irq_s = lsync2_r[2:0];
   wire link_lock = req_tgl_r ^ ack_s;
   wire cmd_take  = link_wr_valid_in && !link_lock && cmd_cnt_r < 4'(CMD_BYTES);
   wire frame_end = link_wr_last_in && !link_lock && (cmd_cnt_r != 4'h0 || cmd_take);
   wire [7:0] status_l = {ready_s && !link_lock, err_s, 3'h0, irq_s};
   wire [7:0] rd_sel   = (link_rd_idx_in == 4'h0) ? status_l :
                         (link_rd_idx_in <= 4'(RESP_USED)) ? resp_r[link_rd_idx_in[2:0]] :
                         8'h00;

   // Two-flop crossing of bus enable, handshake and status into the link.
   always_ff @(posedge link_clk_in) begin
      lsync1_r <= {bus_en_r, ack_tgl_r, err_r, ready_r, irq_r};
      lsync2_r <= lsync1_r;
   end

   // Command bytes collect while unlocked; the frame end raises a request.
   always_ff @(posedge link_clk_in) begin
      if (!bus_en_s) begin
         cmd_cnt_r <= 4'h0;
         req_tgl_r <= 1'b0;
      end else if (frame_end) begin
         cmd_cnt_r <= 4'h0;
         req_tgl_r <= ~req_tgl_r;
      end else if (cmd_take) begin
         cmd_cnt_r <= cmd_cnt_r + 4'h1;
      end
   end

   // Command byte storage; frozen while a command is in flight.
   always_ff @(posedge link_clk_in) begin
      if (cmd_take) begin
         cmd_buf_r[cmd_cnt_r[2:0]] <= link_wr_byte_in;
      end
   end

   // Answer byte: live status at index zero, held answer bytes after it.
   always_ff @(posedge link_clk_in) begin
      rd_byte_r <= bus_en_s ? rd_sel : 8'h00;
   end
   assign link_rd_byte_out = rd_byte_r;

   // ---- System side decode; command bytes are stable during execution.
   wire [7:0]  op       = cmd_buf_r[0];
   wire [7:0]  arg1     = cmd_buf_r[1];
   wire [15:0] arg_id   = {cmd_buf_r[2], cmd_buf_r[3]};
   wire [15:0] arg_val  = {cmd_buf_r[4], cmd_buf_r[5]};
   wire        cmd_evt  = req_s2_r ^ req_s3_r;
   wire        exec     = (state_r == ST_EXEC);
   wire        allowed  = powered_r || (op == CMD_POWER_UP);
   wire        go       = exec && allowed;
   wire        is_pu    = go && op == CMD_POWER_UP;
   wire        is_pd    = go && op == CMD_POWER_DOWN;
   wire        is_set   = go && op == CMD_WRITE_SETTING;
   wire        is_get   = go && op == CMD_READ_SETTING;
   wire        is_tune  = go && op == CMD_TUNE_CHANNEL;
   wire        is_seek  = go && op == CMD_BEGIN_SEARCH;
   wire        is_tstat = go && op == CMD_TUNING_REPORT;
   wire        is_qual  = go && op == CMD_QUALITY_REPORT;
   wire        is_rds   = go && op == CMD_RDS_REPORT;
   wire        is_pdir  = go && op == CMD_PIN_DIRECTION;
   wire        is_plvl  = go && op == CMD_PIN_LEVEL;
   wire        known    = is_pu || is_pd || is_set || is_get || is_tune || is_seek
                          || is_tstat || is_qual || is_rds || is_pdir || is_plvl
                          || (go && op == CMD_READ_REVISION)
                          || (go && op == CMD_READ_IRQ_FLAGS);
   wire        prop_hit;
   wire [15:0] prop_rd;
   logic [15:0] pv [PROP_NUM];
   wire        refclk_bad = arg_id == PROP_ID[P_REFCLK] && arg_val != 16'h0000
                            && (arg_val < REFCLK_MIN || arg_val > REFCLK_MAX);
   wire        prop_wr  = is_set && prop_hit && !refclk_bad;
   wire        err_nxt  = !known || (is_set && (!prop_hit || refclk_bad))
                          || (is_get && !prop_hit) || (is_pu && arg1[3:0] != 4'h0);

   // Tuning error magnitude against the programmed maximum.
   wire [7:0]  err_mag   = freq_err_in[7] ? 8'(-freq_err_in) : 8'(freq_err_in);
   wire        rail_flag = {8'h00, err_mag} > pv[P_MAX_ERR];
   // Seek step inside the band edges, wrapping at either edge.
   wire [15:0] step_up   = freq_r + pv[P_SPACING];
   wire [15:0] step_dn   = freq_r - pv[P_SPACING];
   wire [15:0] seek_nxt  = arg1[SEEK_UP_BIT]
                           ? ((step_up > pv[P_BAND_HI]) ? pv[P_BAND_LO] : step_up)
                           : ((step_dn < pv[P_BAND_LO] || freq_r < pv[P_SPACING])
                              ? pv[P_BAND_HI] : step_dn);
   // Event sources for the sticky flags.
   wire        tune_done = (tune_cnt_r == TCW'(1));
   wire [15:0] qsrc      = pv[P_QUAL_SRC];
   wire        qual_evt  = powered_r && (
                           (qsrc[0] && {8'h00, rssi_in} < pv[P_RSSI_LO]) ||
                           (qsrc[1] && {8'h00, rssi_in} > pv[P_RSSI_HI]) ||
                           (qsrc[2] && {8'h00, snr_in}  < pv[P_SNR_LO])  ||
                           (qsrc[3] && {8'h00, snr_in}  > pv[P_SNR_HI]));
   wire        rds_groups_received_flag  = rds_count_in != 8'h00
                           && {8'h00, rds_count_in} >= pv[P_RDS_LVL];
   wire        rds_evt   = powered_r && pv[P_RDS_SRC][0] && rds_groups_received_flag;
   wire [2:0]  irq_set   = {rds_evt, qual_evt, tune_done};
   wire [2:0]  irq_clr   = {is_rds && arg1[0], is_qual && arg1[0], is_tstat && arg1[0]};
   wire [2:0]  irq_en    = pv[P_IRQ_EN][2:0];
   wire        irq_mode  = |irq_en;

   fmrx_prop_store u_props (
      .clk_in   (sys_clk_in),
      .rst_in   (rst_in),
      .wr_in    (prop_wr),
      .id_in    (arg_id),
      .data_in  (arg_val),
      .hit_out  (prop_hit),
      .rd_out   (prop_rd),
      .vals_out (pv)
   );

   // Answer bytes after the status byte, per command.
   always_comb begin
      for (int k = 1; k <= RESP_USED; k++) begin
         resp_nxt[k] = 8'h00;
      end
      if (go && op == CMD_READ_REVISION) begin
         resp_nxt[1] = PART_ID;
      end else if (is_get) begin
         resp_nxt[2] = prop_rd[15:8];
         resp_nxt[3] = prop_rd[7:0];
      end else if (is_tstat) begin
         resp_nxt[1] = {6'h00, rail_flag, 1'b0};
         resp_nxt[2] = freq_r[15:8];
         resp_nxt[3] = freq_r[7:0];
         resp_nxt[4] = rssi_in;
         resp_nxt[5] = snr_in;
      end else if (is_qual) begin
         resp_nxt[2] = {6'h00, rail_flag, 1'b0};
         resp_nxt[4] = rssi_in;
         resp_nxt[5] = snr_in;
      end else if (is_rds) begin
         resp_nxt[1] = {7'h00, rds_groups_received_flag};
         resp_nxt[3] = rds_count_in;
      end
   end

   // Request handshake: three flops, edge taken between the last two.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         {req_s1_r, req_s2_r, req_s3_r} <= 3'b000;
      end else begin
         {req_s1_r, req_s2_r, req_s3_r} <= {req_tgl_r, req_s1_r, req_s2_r};
      end
   end

   // Engine: ready falls on acceptance, rises with the answer stored.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_r   <= ST_IDLE;
         ready_r   <= 1'b1;
         ack_tgl_r <= 1'b0;
         err_r     <= 1'b0;
         bus_en_r  <= 1'b0;
      end else begin
         bus_en_r <= 1'b1;
         unique case (state_r)
            ST_IDLE: if (cmd_evt) begin
               state_r <= ST_EXEC;
               ready_r <= 1'b0;
            end
            ST_EXEC: begin
               state_r   <= ST_IDLE;
               ready_r   <= 1'b1;
               err_r     <= err_nxt;
               ack_tgl_r <= ~ack_tgl_r;
            end
         endcase
      end
   end

   // Answer store, written only while ready is low.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         resp_r <= '{default: 8'h00};
      end else if (exec) begin
         resp_r <= resp_nxt;
      end
   end

   // Power state and operating mode.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         {powered_r, digital_r, analog_r, xtal_r} <= 4'h0;
      end else if (is_pu && arg1[3:0] == 4'h0) begin
         powered_r <= 1'b1;
         xtal_r    <= arg1[PU_XTAL_BIT];
         analog_r  <= cmd_buf_r[2][PU_ANALOG_BIT];
         digital_r <= cmd_buf_r[2][PU_DIGITAL_BIT];
      end else if (is_pd) begin
         powered_r <= 1'b0;
      end
   end

   // Tune frequency and settle counter for tune and seek.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         freq_r     <= PROP_DEF[P_BAND_LO];
         tune_cnt_r <= '0;
      end else if (is_tune || is_seek) begin
         freq_r     <= is_tune ? arg_id : seek_nxt;
         tune_cnt_r <= TUNE_LOAD;
      end else if (tune_cnt_r != '0) begin
         tune_cnt_r <= tune_cnt_r - TCW'(1);
      end
   end

   // Sticky flags: a set in the same cycle as its clear wins.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         irq_r <= 3'h0;
      end else begin
         irq_r <= (irq_r & ~irq_clr) | irq_set;
      end
   end

   // Pin configuration from the direction and level commands.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pin_oe_r  <= 3'h0;
         pin_lvl_r <= 3'h0;
      end else if (is_pdir) begin
         pin_oe_r  <= arg1[3:1];
      end else if (is_plvl) begin
         pin_lvl_r <= arg1[3:1];
      end
   end

   // Registered pins; pin two turns into an active-low interrupt line.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pin_out_r <= 3'h0;
         pin_oen_r <= 3'h0;
      end else begin
         pin_out_r <= irq_mode ? {pin_lvl_r[2], ~|(irq_r & irq_en), pin_lvl_r[0]}
                               : pin_lvl_r;
         pin_oen_r <= pin_oe_r | {1'b0, irq_mode, 1'b0};
      end
   end
   assign general_output_pin_out    = pin_out_r;
   assign general_output_pin_oe_out = pin_oen_r;

   // Data entry removal strobe and radio controls.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pop_r <= 1'b0;
         ctl_r <= 9'h000;
      end else begin
         pop_r <= is_rds && rds_count_in != 8'h00;
         ctl_r <= {powered_r && analog_r,
                   powered_r && digital_r && pv[P_DA_RATE] != 16'h0000,
                   powered_r && pv[P_REFCLK] != 16'h0000,
                   pv[P_STEREO] == 16'h0000 || pv[P_MONO] == 16'h0000,
                   pv[P_STEREO] == BLEND_MONO || pv[P_MONO] == BLEND_MONO,
                   pv[P_SMUTE] != 16'h0000,
                   powered_r && pv[P_MUTE][1],
                   powered_r && pv[P_MUTE][0],
                   xtal_r};
      end
   end
   assign rds_pop_out = pop_r;
   assign {analog_en_out, digital_audio_en_out, freq_ctl_en_out, stereo_force_out,
           mono_force_out, softmute_en_out, mute_left_out, mute_right_out,
           xtal_sel_out} = ctl_r;
   assign tune_freq_out = freq_r;

   // ---- Checks on the system domain.
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   a_ready_window: assert property (cmd_evt && state_r == ST_IDLE |=> !ready_r ##1 ready_r)
      else $error("ready did not drop and return");
   a_answer_pair: assert property ($rose(ready_r) |-> $changed(ack_tgl_r))
      else $error("ready rose without handshake");
   a_reset_restore: assert property (disable iff (1'b0)
                                     rst_in |=> pv[P_REFCLK] == 16'h8000 && !powered_r)
      else $error("reset did not restore defaults");
   a_refclk_reject: assert property (is_set && refclk_bad |=> err_r && $stable(pv[P_REFCLK]))
      else $error("bad clock value accepted");
   a_tune_settle: assert property (tune_cnt_r == TCW'(1) |=> irq_r[0])
      else $error("tune flag not set at end of settle");
   a_seek_band: assert property (is_seek && pv[P_BAND_LO] <= pv[P_BAND_HI]
                                 |=> freq_r >= pv[P_BAND_LO] && freq_r <= pv[P_BAND_HI])
      else $error("seek left the band");
   a_pop_once: assert property (rds_pop_out |=> !rds_pop_out)
      else $error("data pop longer than one cycle");
   a_irq_pin: assert property (irq_mode && |(irq_r & irq_en) |=> ##1
                               !general_output_pin_out[1] && general_output_pin_oe_out[1])
      else $error("interrupt pin not asserted");
   a_powerdown_bus: assert property (!powered_r && cmd_evt && state_r == ST_IDLE
                                     |-> ##2 ready_r && bus_en_r)
      else $error("bus not served in power-down");
   a_mute_gate: assert property (mute_left_out || mute_right_out |-> $past(powered_r))
      else $error("mute while powered down");

   c_power_up: cover property (is_pu ##1 powered_r);
   c_set_get: cover property (prop_wr ##[1:200] is_get);
   // Settle is longer than a delay range may span; the counter's last step stands in.
   c_seek_done: cover property (tune_done && !is_tune && !is_seek ##1 irq_r[0]);
   c_set_clear: cover property (irq_set[0] && irq_clr[0]);
endmodule
`default_nettype wire

// ---- verif/fmrx_host.sv ----
// Host controller model: sends command frames and reads answer bytes.
// Assumes the bench runs the link clock and calls these tasks.
`timescale 1ns/1ps
`default_nettype none
module fmrx_host (
   // Link side.
   input  wire logic       lclk_in,
   input  wire logic [7:0] rd_byte_in,
   output logic            valid_out,
   output logic [7:0]      byte_out,
   output logic            last_out,
   output logic [3:0]      idx_out
);
   // Idle link values at time zero.
   initial begin
      valid_out = 1'b0;
      byte_out = 8'h00;
      last_out = 1'b0;
      idx_out = 4'h0;
   end
   // Reads one answer byte; the byte lags the index by one link edge.
   task automatic rd(input logic [3:0] i, output logic [7:0] v);
      @(negedge lclk_in) idx_out = i;
      @(negedge lclk_in) v = rd_byte_in;
   endtask
   // Polls status until ready, with a bounded number of tries.
   task automatic poll(output logic [7:0] s, output bit hung);
      hung = 1'b1;
      for (int n = 0; n < 64 && hung; n++) begin
         rd(4'h0, s);
         hung = !s[7];
      end
   endtask
   // Sends one whole frame once ready, then waits for the answer.
   task automatic send(input logic [7:0] b[$], output logic [7:0] s, output bit hung);
      poll(s, hung);
      for (int i = 0; i < b.size() && i < 8; i++) begin
         @(negedge lclk_in);
         valid_out = 1'b1;
         byte_out = b[i];
         last_out = (i == b.size() - 1);
      end
      @(negedge lclk_in);
      valid_out = 1'b0;
      last_out = 1'b0;
      byte_out = ~byte_out;
      repeat (8) @(negedge lclk_in);
      poll(s, hung);
   endtask
endmodule
`default_nettype wire

// ---- verif/fm_receiver_command_property_core_tb.sv ----
// Self-checking bench of the FM receiver command core with a host model.
// Assumes a 40 MHz system clock and a free 48 ns link clock.
`timescale 1ns/1ps
`default_nettype none
module fm_receiver_command_property_core_tb;
   import fmrx_pkg::*;
   localparam logic [7:0] ID_CODE = 8'hC3; // Arbitrary identity value.
   logic sys_clk_in = 0, lclk = 0, rst_in = 1, valid, last, an, da, xt, fc, sf, mf, sm, ml, mr;
   logic [7:0] rssi = 0, wb, rd_byte, st, v, w;
   logic [3:0] idx;
   logic [15:0] tf;
   logic [2:0] gp, goe;
   logic [15:0] model [int];
   int errors = 0, checks = 0;
   bit hung;
   // Clocks of unrelated phase.
   always #12.5 sys_clk_in = ~sys_clk_in;
   initial begin #7; forever #24 lclk = ~lclk; end
   fmrx_core #(.PART_ID(ID_CODE)) fmrx_core_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .link_clk_in(lclk), .link_wr_valid_in(valid), .link_wr_byte_in(wb),
      .link_wr_last_in(last), .link_rd_idx_in(idx), .link_rd_byte_out(rd_byte),
      .freq_err_in(8'sh00), .rssi_in(rssi), .snr_in(8'h00), .rds_count_in(8'h00),
      .rds_pop_out(), .analog_en_out(an), .digital_audio_en_out(da), .xtal_sel_out(xt),
      .freq_ctl_en_out(fc), .stereo_force_out(sf), .mono_force_out(mf), .softmute_en_out(sm),
      .mute_left_out(ml), .mute_right_out(mr), .tune_freq_out(tf),
      .general_output_pin_out(gp), .general_output_pin_oe_out(goe));
   fmrx_host fmrx_host_inst (.lclk_in(lclk), .rd_byte_in(rd_byte), .valid_out(valid),
      .byte_out(wb), .last_out(last), .idx_out(idx));
   // Compares one value and reports a mismatch.
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Runs one command; a hang counts as a mismatch.
   task automatic cmd(input logic [7:0] b[$]);
      fmrx_host_inst.send(b, st, hung);
      if (hung) begin
         errors++;
         summarize();
      end
   endtask
   // Writes a setting and updates the model when it is accepted.
   task automatic setp(input logic [15:0] id, input logic [15:0] d, input logic e);
      cmd('{8'h12, 8'h00, id[15:8], id[7:0], d[15:8], d[7:0]});
      chk(st[6], e);
      if (!e) model[id] = d;
   endtask
   // Reads a setting back and compares it with the model.
   task automatic getp(input logic [15:0] id);
      cmd('{8'h13, 8'h00, id[15:8], id[7:0]});
      fmrx_host_inst.rd(4'h2, v);
      fmrx_host_inst.rd(4'h3, w);
      chk({v, w}, model[id]);
   endtask
   // Main sequence.
   initial begin
      void'($urandom(32'hC981));
      rssi = $urandom;
      foreach (PROP_ID[i]) model[PROP_ID[i]] = PROP_DEF[i];
      repeat (5) @(negedge sys_clk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge lclk);
      chk({an, goe}, 16'h0000);
      chk(tf, 16'h222E);
      cmd('{8'h22, 8'h00});
      chk(st[6], 1'b1);
      cmd('{8'h01, 8'h00, 8'h01});
      chk({st[6], an}, 16'h0001);
      foreach (PROP_ID[i]) getp(PROP_ID[i]);
      cmd('{8'h10});
      fmrx_host_inst.rd(4'h1, v);
      chk(v, ID_CODE);
      setp(16'h4001, 16'($urandom % 4), 1'b0);
      chk({ml, mr}, model[16'h4001]);
      setp(16'h1105, 16'h0000, 1'b0);
      chk(sf, 1'b1);
      setp(16'h1302, 16'h0000, 1'b0);
      chk(sm, 1'b0);
      setp(16'h0201, 16'h0000, 1'b0);
      chk(fc, 1'b0);
      setp(16'h0201, 16'h8667, 1'b1);
      setp(16'h0003, 16'h0001, 1'b1);
      setp(16'h0201, 16'h799A, 1'b0);
      getp(16'h0201);
      chk(fc, 1'b1);
      cmd('{8'h80, 8'h08});
      cmd('{8'h81, 8'h08});
      chk({goe[2], gp[2]}, 16'h0003);
      cmd('{8'h80, 8'h00});
      chk(goe[2], 1'b0);
      for (int c = 8'h15; c <= 8'h16; c++) begin
         cmd('{8'(c)});
         chk(st[6], 1'b1);
      end
      cmd('{8'h20, 8'h00, 8'h23, 8'h28});
      chk(tf, 16'h2328);
      repeat (TUNE_CYC + 20) @(negedge sys_clk_in);
      cmd('{8'h22, 8'h00});
      chk(st[0], 1'b1);
      fmrx_host_inst.rd(4'h2, v);
      fmrx_host_inst.rd(4'h3, w);
      chk({v, w}, 16'h2328);
      cmd('{8'h22, 8'h01});
      chk(st[0], 1'b0);
      cmd('{8'h23, 8'h00});
      fmrx_host_inst.rd(4'h4, v);
      chk(v, rssi);
      cmd('{8'h11});
      chk(an, 1'b0);
      cmd('{8'h01, 8'h00, 8'h01});
      chk({st[6], an}, 16'h0001);
      summarize();
   end
endmodule
`default_nettype wire
